// [tpu_defs.svh]
// offsets, field positions, reset values and sequence counts of the trace port unit
// assumes a 12-bit apb byte address and an 8-bit trace port
`ifndef TPU_DEFS_SVH
`define TPU_DEFS_SVH

`define TPU_CTRL_OFS      12'h000
`define TPU_STATUS_OFS    12'h004
`define TPU_SYNC_OFS      12'h008
`define TPU_PAT_CTRL_OFS  12'h00c
`define TPU_PAT_LEN_OFS   12'h010

`define CTRL_FMT_EN       0
`define CTRL_CONT         1
`define CTRL_HALT_FL      4
`define CTRL_MAN_FL       5
`define STAT_FLUSHING     0
`define STAT_HALTED       1
`define PAT_EN            0
`define PAT_TIMED         1

`define PAT_CNT_W         16
`define SYNC_CNT_W        12
`define PAT_LEN_RST       16'h0040
`define SYNC_FRAMES_RST   12'h0040
`define FMT_EN_RST        1'b0

`define SYNC_LAST_IDX     2'h3
`define FRAME_LAST_IDX    4'hf
`define SYNC_FILL         8'hff
`define SYNC_TAIL         8'h7f
`define FRAME_HDR         8'ha5
`define PAD_BYTE          8'h00
`define PAT_SEED          8'h01

`endif

// [tpu_pkg.sv]
// types of the trace port unit: formatter states and the state record
// assumes tpu_defs.svh is on the include path
package tpu_pkg;
  `include "tpu_defs.svh"

  typedef enum logic [2:0] {
    ST_PATTERN = 3'b000,
    ST_SYNC    = 3'b001,
    ST_HEADER  = 3'b010,
    ST_DATA    = 3'b011,
    ST_STOPPED = 3'b100
  } fmt_state_e;

  typedef struct packed {
    fmt_state_e              st;
    logic                    fmt_en;
    logic                    cont;
    logic                    halt_fl;
    logic                    flush_req;
    logic                    halted;
    logic                    pat_en;
    logic                    pat_timed;
    logic [`PAT_CNT_W-1:0]   pat_len;
    logic [`PAT_CNT_W-1:0]   pat_cnt;
    logic [`SYNC_CNT_W-1:0]  sync_frames;
    logic [`SYNC_CNT_W-1:0]  frame_cnt;
    logic [3:0]              byte_cnt;
    logic [1:0]              sync_idx;
    logic [7:0]              pat_word;
    logic [7:0]              out_data;
    logic                    out_valid;
    logic [31:0]             prdata;
    logic                    pslverr;
  } tpu_s;
endpackage : tpu_pkg

// [stream_if.sv]
// valid/ready word stream between the trace unit and its buffer
// assumes both ends run on the same clock
`timescale 1ns/10ps
interface stream_if #(parameter int W = 8) ();
  logic         valid;
  logic         ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface : stream_if

// [trace_skid_buffer.sv]
// small fifo with valid/ready on both sides, full stalls the filling side
// assumes one clock and asynchronous active-low reset
`timescale 1ns/10ps
module trace_skid_buffer #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 2
) (
  input  wire logic clk,
  input  wire logic arst_n,
  stream_if.snk     in_s,
  stream_if.src     out_s
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0]               wr;
    logic [AW-1:0]               rd;
    logic [CW-1:0]               cnt;
  } buf_s;

  buf_s r;
  buf_s next_r;
  logic push;
  logic pop;

  assign in_s.ready  = (r.cnt != CW'(DEPTH));
  assign out_s.valid = (r.cnt != '0);
  assign out_s.data  = r.mem[r.rd];
  assign push        = in_s.valid & in_s.ready;
  assign pop         = out_s.valid & out_s.ready;

  always_comb begin
    next_r = r;
    if (push) begin
      next_r.mem[r.wr] = in_s.data;
      next_r.wr        = (r.wr == AW'(DEPTH - 1)) ? '0 : r.wr + AW'(1);
    end
    if (pop) begin
      next_r.rd = (r.rd == AW'(DEPTH - 1)) ? '0 : r.rd + AW'(1);
    end
    if (push && !pop) begin
      next_r.cnt = r.cnt + CW'(1);
    end else if (pop && !push) begin
      next_r.cnt = r.cnt - CW'(1);
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end
endmodule : trace_skid_buffer

// [trace_port_output_unit.sv]
// trace port output unit: pattern generator, trace formatter, apb registers
// assumes apb master on clk, trace source on clk, analyzer samples every cycle
//
// Contract
// RULE1: timed pattern runs the programmed cycle count, then trace data resumes.
// RULE2: a sync sequence is sent between pattern end and trace data.
// RULE3: continuous bit at 0 is normal mode; post-pattern sync still required.
// RULE4: sync is inserted each time the programmed frame count is sent.
// RULE5: formatter enable at 1 wraps trace data into frames.
// RULE6: timed pattern enable at 1 runs the pattern for its duration only.
// RULE7: trace input arriving during the pattern is discarded, not buffered.
// RULE8: halt-after-flush plus manual flush flush pending data then stop formatter.
// RULE9: halted flag reads 1 once stopping completes; software polls it.
// RULE10: re-enabling the formatter sends sync before formatted data resumes.
// RULE11: halted flag clears when software re-enables the formatter.
//
// The register addresses and the APB slave port were left to the implementer.
`timescale 1ns/10ps
module trace_port_output_unit
  import tpu_pkg::*;
#(
  parameter int BUF_DEPTH = 2
) (
  input  wire logic        clk,
  input  wire logic        arst_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output      logic [31:0] prdata,
  output      logic        pready,
  output      logic        pslverr,
  input  wire logic        trace_valid,
  input  wire logic [7:0]  trace_data,
  output      logic        trace_ready,
  output      logic [7:0]  trace_port_data,
  output      logic        trace_port_valid
);
  `include "tpu_defs.svh"

  ////////////////////////////////////////////////////////////////////////////
  // input buffer
  stream_if #(.W(8)) in_if ();
  stream_if #(.W(8)) out_if ();

  tpu_s r;
  tpu_s next_r;
  logic wr_en;
  logic setup;
  logic bypass;

  assign bypass       = (r.st == ST_PATTERN);
  assign in_if.valid  = trace_valid & ~bypass;                // [RULE7]
  assign in_if.data   = trace_data;
  assign trace_ready  = bypass | in_if.ready;                 // [RULE7]
  assign out_if.ready = (r.st == ST_DATA) | bypass;

  trace_skid_buffer #(
    .WIDTH (8),
    .DEPTH (BUF_DEPTH)
  ) u_buf (
    .clk    (clk),
    .arst_n (arst_n),
    .in_s   (in_if),
    .out_s  (out_if)
  );

  ////////////////////////////////////////////////////////////////////////////
  // apb handshake and outputs
  assign setup            = psel & ~penable;
  assign wr_en            = psel & penable & pwrite;
  assign pready           = psel & penable;
  assign prdata           = r.prdata;
  assign pslverr          = pready & r.pslverr;
  assign trace_port_data  = r.out_data;
  assign trace_port_valid = r.out_valid;

  ////////////////////////////////////////////////////////////////////////////
  // formatter, pattern generator and registers
  always_comb begin
    next_r           = r;
    next_r.out_valid = 1'b0;
    next_r.out_data  = `PAD_BYTE;
    case (r.st)
      ST_PATTERN: begin
        next_r.out_valid = 1'b1;
        next_r.out_data  = r.pat_word;
        next_r.pat_word  = {r.pat_word[6:0], r.pat_word[7]};
        if (r.pat_timed) begin                                // [RULE6]
          next_r.pat_cnt = r.pat_cnt + `PAT_CNT_W'(1);
          if (r.pat_cnt == r.pat_len - `PAT_CNT_W'(1)) begin  // [RULE1]
            next_r.pat_en   = 1'b0;
            next_r.st       = ST_SYNC;                         // [RULE2] [RULE3]
            next_r.sync_idx = '0;
          end
        end else if (!r.pat_en) begin
          next_r.st       = ST_SYNC;                           // [RULE2]
          next_r.sync_idx = '0;
        end
      end
      ST_SYNC: begin
        next_r.out_valid = 1'b1;
        next_r.out_data  = (r.sync_idx == `SYNC_LAST_IDX) ? `SYNC_TAIL : `SYNC_FILL;
        next_r.sync_idx  = r.sync_idx + 2'h1;
        if (r.sync_idx == `SYNC_LAST_IDX) begin
          next_r.frame_cnt = '0;
          next_r.byte_cnt  = '0;
          next_r.st        = r.fmt_en ? ST_HEADER : ST_DATA;   // [RULE5]
        end
      end
      ST_HEADER: begin
        if (r.flush_req && !out_if.valid) begin
          next_r.st = ST_DATA;
        end else begin
          next_r.out_valid = 1'b1;
          next_r.out_data  = `FRAME_HDR;                       // [RULE5]
          next_r.byte_cnt  = 4'h1;
          next_r.st        = ST_DATA;
        end
      end
      ST_DATA: begin
        if (out_if.valid || (r.flush_req && r.fmt_en && r.byte_cnt != 4'h0)) begin
          next_r.out_valid = 1'b1;
          next_r.out_data  = out_if.valid ? out_if.data : `PAD_BYTE;
          if (r.fmt_en) begin
            next_r.byte_cnt = r.byte_cnt + 4'h1;
            if (r.byte_cnt == `FRAME_LAST_IDX) begin
              next_r.byte_cnt  = '0;
              next_r.frame_cnt = r.frame_cnt + `SYNC_CNT_W'(1);
              next_r.st        = ST_HEADER;
              if (r.sync_frames != '0 &&
                  r.frame_cnt + `SYNC_CNT_W'(1) >= r.sync_frames) begin
                next_r.st       = ST_SYNC;                     // [RULE4]
                next_r.sync_idx = '0;
              end
            end
          end
        end else if (r.flush_req) begin
          next_r.flush_req = 1'b0;                             // [RULE8]
          if (r.halt_fl) begin
            next_r.st     = ST_STOPPED;                        // [RULE8]
            next_r.fmt_en = 1'b0;
            next_r.halted = 1'b1;                              // [RULE9]
          end
        end
      end
      ST_STOPPED: begin
        next_r.out_valid = 1'b0;
      end
      default: begin
        next_r.st = ST_STOPPED;
      end
    endcase

    // pattern start takes over the port from any running state that is not stopping in this cycle
    if (r.pat_en && r.st != ST_PATTERN && r.st != ST_STOPPED &&
        next_r.st != ST_STOPPED) begin
      next_r.st       = ST_PATTERN;
      next_r.pat_cnt  = '0;
      next_r.pat_word = `PAT_SEED;
    end

    // register writes after the state machine, so a write wins over a state machine update in the same cycle
    if (wr_en) begin
      if (paddr == `TPU_CTRL_OFS) begin
        next_r.cont    = pwdata[`CTRL_CONT];                   // [RULE3]
        next_r.halt_fl = pwdata[`CTRL_HALT_FL];
        if (pwdata[`CTRL_MAN_FL]) begin
          next_r.flush_req = 1'b1;                             // [RULE8]
        end
        if (pwdata[`CTRL_FMT_EN] && !next_r.fmt_en) begin
          next_r.halted = 1'b0;                                // [RULE11]
          if (next_r.st != ST_PATTERN) begin
            next_r.st       = ST_SYNC;                         // [RULE10]
            next_r.sync_idx = '0;
          end
        end
        next_r.fmt_en = pwdata[`CTRL_FMT_EN];
      end else if (paddr == `TPU_SYNC_OFS) begin
        next_r.sync_frames = pwdata[`SYNC_CNT_W-1:0];
      end else if (paddr == `TPU_PAT_CTRL_OFS) begin
        next_r.pat_en    = pwdata[`PAT_EN];
        next_r.pat_timed = pwdata[`PAT_TIMED];
      end else if (paddr == `TPU_PAT_LEN_OFS) begin
        next_r.pat_len = pwdata[`PAT_CNT_W-1:0];
      end
    end

    // read data and error captured in the setup cycle
    if (setup) begin
      next_r.prdata  = '0;
      next_r.pslverr = 1'b0;
      if (paddr == `TPU_CTRL_OFS) begin
        next_r.prdata[`CTRL_FMT_EN]  = r.fmt_en;
        next_r.prdata[`CTRL_CONT]    = r.cont;
        next_r.prdata[`CTRL_HALT_FL] = r.halt_fl;
        next_r.prdata[`CTRL_MAN_FL]  = r.flush_req;
      end else if (paddr == `TPU_STATUS_OFS) begin
        next_r.prdata[`STAT_FLUSHING] = r.flush_req;
        next_r.prdata[`STAT_HALTED]   = r.halted;          // [RULE9]
      end else if (paddr == `TPU_SYNC_OFS) begin
        next_r.prdata[`SYNC_CNT_W-1:0] = r.sync_frames;
      end else if (paddr == `TPU_PAT_CTRL_OFS) begin
        next_r.prdata[`PAT_EN]    = r.pat_en;
        next_r.prdata[`PAT_TIMED] = r.pat_timed;
      end else if (paddr == `TPU_PAT_LEN_OFS) begin
        next_r.prdata[`PAT_CNT_W-1:0] = r.pat_len;
      end else begin
        next_r.pslverr = 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      r             <= '0;
      r.st          <= ST_DATA;
      r.fmt_en      <= `FMT_EN_RST;
      r.pat_len     <= `PAT_LEN_RST;
      r.sync_frames <= `SYNC_FRAMES_RST;
      r.pat_word    <= `PAT_SEED;
    end else begin
      r <= next_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // assertions
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  property p_timed_end;
    (r.st == ST_PATTERN && r.pat_timed && !wr_en &&
     r.pat_cnt == r.pat_len - `PAT_CNT_W'(1)) |=> (r.st == ST_SYNC && !r.pat_en);
  endproperty
  a_timed_end: assert property (p_timed_end) else $error("timed pattern overran"); // [RULE1]

  property p_sync_after_pat;
    (r.st == ST_PATTERN) ##1 (r.st != ST_PATTERN) |->
      (r.st == ST_SYNC) [*4] ##1 (r.st != ST_SYNC);
  endproperty
  a_sync_after_pat: assert property (p_sync_after_pat) else $error("no sync after pattern"); // [RULE2]

  property p_normal_sync;
    (r.st == ST_PATTERN && !r.cont) ##1 (r.st != ST_PATTERN) |=>
      (trace_port_valid && trace_port_data == `SYNC_FILL);
  endproperty
  a_normal_sync: assert property (p_normal_sync) else $error("normal mode sync missing"); // [RULE3]

  property p_periodic;
    (r.st == ST_DATA && r.fmt_en && out_if.valid && !wr_en && !r.pat_en &&
     r.byte_cnt == `FRAME_LAST_IDX && r.sync_frames != '0 &&
     r.frame_cnt + `SYNC_CNT_W'(1) >= r.sync_frames) |=> (r.st == ST_SYNC);
  endproperty
  a_periodic: assert property (p_periodic) else $error("periodic sync skipped"); // [RULE4]

  property p_header;
    (r.st == ST_HEADER && !r.flush_req && !r.pat_en && !wr_en) |=>
      (trace_port_valid && trace_port_data == `FRAME_HDR && r.byte_cnt == 4'h1);
  endproperty
  a_header: assert property (p_header) else $error("frame header missing"); // [RULE5]

  property p_untimed_holds;
    (r.st == ST_PATTERN && !r.pat_timed && r.pat_en && !wr_en) |=> (r.st == ST_PATTERN);
  endproperty
  a_untimed_holds: assert property (p_untimed_holds) else $error("untimed pattern ended"); // [RULE6]

  property p_discard;
    (r.st == ST_PATTERN) |-> (trace_ready && !in_if.valid);
  endproperty
  a_discard: assert property (p_discard) else $error("trace kept during pattern"); // [RULE7]

  property p_stop;
    (r.st == ST_DATA && r.flush_req && r.halt_fl && !out_if.valid && !wr_en &&
     (r.byte_cnt == 4'h0 || !r.fmt_en) && !r.pat_en) |=>
      (r.st == ST_STOPPED && !r.fmt_en && !r.flush_req);
  endproperty
  a_stop: assert property (p_stop) else $error("flush did not stop formatter"); // [RULE8]

  property p_halted_flag;
    r.halted == (r.st == ST_STOPPED);
  endproperty
  a_halted_flag: assert property (p_halted_flag) else $error("halted flag wrong"); // [RULE9]

  property p_resync;
    (r.st == ST_STOPPED) ##1 (r.st != ST_STOPPED) |->
      (r.st == ST_SYNC && r.sync_idx == 2'h0 && !r.halted);
  endproperty
  a_resync: assert property (p_resync) else $error("restart without sync"); // [RULE10] [RULE11]

  c_timed_done: cover property ((r.st == ST_PATTERN && r.pat_timed) ##1 (r.st == ST_SYNC));
  c_stopped:    cover property ((r.st == ST_DATA && r.flush_req) ##1 (r.st == ST_STOPPED));
  c_restart:    cover property ((r.st == ST_STOPPED) ##1 (r.st == ST_SYNC));
  c_full_buf:   cover property (in_if.valid && !in_if.ready);
endmodule : trace_port_output_unit

// [trace_analyzer_model.sv]
// capture model of the external analyzer on the trace port
// assumes one byte per clock while valid is high, same clock as the unit
`timescale 1ns/10ps
module trace_analyzer_model (
  input  wire logic       clk,
  input  wire logic       arst_n,
  input  wire logic [7:0] port_data,
  input  wire logic       port_valid,
  output int              bad_idle
);
  logic [7:0] q[$];
  initial bad_idle = 0;
  // capture meaningful bytes, idle cycles must show zero
  always @(posedge clk) begin
    if (arst_n === 1'b1 && port_valid === 1'b1) begin
      q.push_back(port_data);
    end else if (arst_n === 1'b1 && port_data !== 8'h00) begin
      bad_idle++;
    end
  end
endmodule : trace_analyzer_model

// [trace_port_output_unit_test.sv]
// self-checking bench of the trace port unit against a queue model
// assumes the analyzer model and the design files are compiled first
`timescale 1ns/10ps
module trace_port_output_unit_test;
  import tpu_pkg::*;
  logic        clk, arst_n, psel, penable, pwrite, trace_valid;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic        pready, pslverr, trace_ready, trace_port_valid, e;
  logic [7:0]  trace_data, trace_port_data, b;
  logic [7:0]  exp_q[$];
  int          n_errors, checks_done, fill, nfr, sf, n, cyc, bad_idle;
  trace_port_output_unit #(.BUF_DEPTH(2)) dut (.clk(clk), .arst_n(arst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .trace_valid(trace_valid), .trace_data(trace_data),
    .trace_ready(trace_ready), .trace_port_data(trace_port_data),
    .trace_port_valid(trace_port_valid));
  trace_analyzer_model cap (.clk(clk), .arst_n(arst_n), .port_data(trace_port_data),
    .port_valid(trace_port_valid), .bad_idle(bad_idle));
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 0;
    forever #4 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      $display("Error at %0t: timeout", $time);
      stop_test();
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  task stop_test();
    $display("errors %0d checks %0d", n_errors, checks_done);
    if (n_errors == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : stop_test
  task cmp(input logic [31:0] got, input logic [31:0] want, input string what);
    checks_done++;
    if (got !== want) begin
      n_errors++;
      $display("Error at %0t: %s got %h exp %h", $time, what, got, want);
    end
  endtask : cmp
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk);
    penable <= 1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 0;
    penable <= 0;
  endtask : apb
  task send(input logic [7:0] d);
    @(posedge clk);
    trace_valid <= 1;
    trace_data  <= d;
    do begin
      @(posedge clk);
    end while (trace_ready !== 1'b1);
    trace_valid <= 0;
  endtask : send
  // model: sync then header, 15 data bytes per frame, sync every sf frames
  task m_sync();
    exp_q.push_back(8'hff); exp_q.push_back(8'hff); exp_q.push_back(8'hff);
    exp_q.push_back(8'h7f); exp_q.push_back(8'ha5);
    fill = 0;
    nfr = 0;
  endtask : m_sync
  task m_data(input logic [7:0] d);
    exp_q.push_back(d);
    fill++;
    send(d);
    if (fill == 15) begin
      nfr++;
      if (sf != 0 && nfr == sf) m_sync();
      else begin
        exp_q.push_back(8'ha5);
        fill = 0;
      end
    end
  endtask : m_data
  task chk_q();
    repeat (40) @(posedge clk);
    cmp(32'(cap.q.size()), 32'(exp_q.size()), "port byte count");
    foreach (exp_q[i]) if (i < cap.q.size()) cmp(32'(cap.q[i]), 32'(exp_q[i]), "port byte");
    exp_q.delete();
    cap.q.delete();
  endtask : chk_q
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    arst_n = 0; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0;
    trace_valid = 0; trace_data = 0; n_errors = 0; checks_done = 0; cyc = 0;
    void'($urandom(32'h45e2));
    repeat (10) @(posedge clk);
    arst_n <= 1;
    apb(0, 12'h008, $urandom); cmp(r, 32'h0000_0040, "sync frames reset");
    apb(0, 12'h010, $urandom); cmp(r, 32'h0000_0040, "pattern len reset");
    apb(0, 12'h000, $urandom); cmp(r, 32'h0000_0000, "ctrl reset");
    apb(0, 12'h004, $urandom); cmp(r, 32'h0000_0000, "status reset");
    apb(0, 12'h0f0, $urandom); cmp({r[30:0], e}, 32'h0000_0001, "unmapped");
    repeat (6) begin
      b = 8'($urandom);
      exp_q.push_back(b);
      send(b);
    end
    chk_q();
    sf = 2;
    apb(1, 12'h008, 32'h0000_0002);
    apb(1, 12'h000, 32'h0000_0001);
    m_sync();
    repeat (40) m_data(8'($urandom));
    apb(1, 12'h000, 32'h0000_0031);
    repeat (15 - fill) exp_q.push_back(8'h00);
    n = 0;
    do begin
      apb(0, 12'h004, $urandom);
      n++;
    end while (r[1] !== 1'b1 && n < 100);
    cmp(32'(r[1]), 32'h0000_0001, "halted flag");
    chk_q();
    apb(0, 12'h000, $urandom); cmp(32'(r[0]), 32'h0000_0000, "formatter off after stop");
    apb(1, 12'h000, 32'h0000_0001);
    apb(0, 12'h004, $urandom); cmp(32'(r[1]), 32'h0000_0000, "halted cleared");
    m_sync();
    repeat (15) m_data(8'($urandom));
    chk_q();
    apb(1, 12'h010, 32'h0000_0005);
    apb(1, 12'h00c, 32'h0000_0003);
    repeat (2) send(8'($urandom));
    for (int i = 0; i < 5; i++) exp_q.push_back(8'h01 << i);
    m_sync();
    repeat (20) @(posedge clk);
    repeat (5) m_data(8'($urandom));
    chk_q();
    apb(1, 12'h00c, 32'h0000_0001);
    repeat (10) @(posedge clk);
    apb(1, 12'h00c, 32'h0000_0000);
    repeat (30) @(posedge clk);
    n = 0;
    while (n < cap.q.size() && cap.q[n] == (8'h01 << (n % 8))) n++;
    cmp(32'(n >= 10), 32'h0000_0001, "untimed pattern length");
    exp_q = '{8'hff, 8'hff, 8'hff, 8'h7f, 8'ha5};
    cmp(32'(cap.q.size()), 32'(n + 5), "untimed tail count");
    foreach (exp_q[i])
      if (n + i < cap.q.size()) cmp(32'(cap.q[n + i]), 32'(exp_q[i]), "untimed tail");
    exp_q.delete();
    cap.q.delete();
    cmp(32'(bad_idle), 32'h0000_0000, "idle port data");
    stop_test();
  end
endmodule : trace_port_output_unit_test
